/* logic/paop_fifo.sv */
`timescale 1ns/1ps
module paop_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [WIDTH-1:0] o_rd_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} paop_fifo_st_t;

	paop_fifo_st_t st_r;
	paop_fifo_st_t st_nxt;
	logic push;
	logic pop;

	always_comb begin
		st_nxt = st_r;
		push = i_wr_valid && (st_r.cnt != FULL_CNT);
		pop = i_rd_ready && (st_r.cnt != '0);
		if (push) begin
			st_nxt.mem[st_r.wp] = i_wr_data;
			st_nxt.wp = (st_r.wp == LAST_PTR) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == LAST_PTR) ? '0 : st_r.rp + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_wr_ready = (st_r.cnt != FULL_CNT);
	assign o_rd_valid = (st_r.cnt != '0);
	assign o_rd_data = st_r.mem[st_r.rp];
endmodule

/* logic/paop_output_path.sv */
`timescale 1ns/1ps
module paop_output_path (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_conv_clk,
	input wire logic [paop_pkg::DATA_W-1:0] i_sample_code,
	input wire logic i_top_bit_flip_select,
	input wire logic i_out_disable,
	output logic [paop_pkg::DATA_W-1:0] o_data,
	output logic o_data_oe_n,
	output logic o_data_valid,
	output logic o_overrun
);
	typedef struct packed {
		logic clk_prev;
		paop_pkg::paop_stage_t [paop_pkg::STAGES-1:0] stg;
		logic corr_vld;
		logic [paop_pkg::DATA_W-1:0] corr;
		logic [paop_pkg::DATA_W-1:0] data;
		logic oe_n;
		logic data_vld;
		logic overrun;
	} paop_state_t;

	paop_state_t st_r;
	paop_state_t st_nxt;
	logic rise;
	logic fall;
	logic step;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic [paop_pkg::DATA_W-1:0] fifo_rd_data;

	// Sum of weighted redundant digits plus the last residue
	function automatic logic [paop_pkg::DATA_W-1:0] paop_correct(
		input paop_pkg::paop_stage_t s
	);
		logic [paop_pkg::DATA_W:0] acc;
		acc = {1'b0, s.res};
		for (int k = 0; k < paop_pkg::STAGES; k++) begin
			acc = acc + ((paop_pkg::DATA_W+1)'(s.dig[k]) << (paop_pkg::STAGES - 1 - k));
		end
		return acc[paop_pkg::DATA_W-1:0];
	endfunction

	assign rise = i_conv_clk && !st_r.clk_prev;
	assign fall = !i_conv_clk && st_r.clk_prev;
	assign step = rise || fall; // [R3]

	always_comb begin
		logic [paop_pkg::DATA_W-1:0] rin;
		logic [paop_pkg::DATA_W-1:0] w;
		logic [paop_pkg::STAGE_BITS-1:0] d;
		logic vin;
		rin = '0;
		w = '0;
		d = '0;
		vin = 1'b0;
		st_nxt = st_r;
		st_nxt.clk_prev = i_conv_clk;
		st_nxt.oe_n = i_out_disable; // [R7]
		st_nxt.corr_vld = 1'b0;
		if (step) begin
			// Each stage shifts one slot per half period; falling slots carry bubbles
			for (int k = 0; k < paop_pkg::STAGES; k++) begin // [R2]
				if (k == 0) begin
					rin = i_sample_code;
					vin = rise;
					st_nxt.stg[k].dig = '0;
				end else begin
					rin = st_r.stg[k-1].res;
					vin = st_r.stg[k-1].vld;
					st_nxt.stg[k].dig = st_r.stg[k-1].dig; // [R4]
				end
				w = paop_pkg::DATA_W'(1) << (paop_pkg::STAGES - 1 - k);
				if (rin >= (w << 1)) begin
					d = paop_pkg::DIGIT_MAX;
				end else if (rin >= w) begin
					d = 2'h1;
				end else begin
					d = 2'h0;
				end
				st_nxt.stg[k].dig[k] = d;
				st_nxt.stg[k].res = rin - (paop_pkg::DATA_W'(d) << (paop_pkg::STAGES - 1 - k));
				st_nxt.stg[k].vld = vin;
			end
			if (st_r.stg[paop_pkg::STAGES-1].vld) begin
				st_nxt.corr = paop_correct(st_r.stg[paop_pkg::STAGES-1]); // [R4]
				st_nxt.corr_vld = 1'b1;
			end
		end
		if (st_r.corr_vld && !fifo_wr_ready) begin
			st_nxt.overrun = 1'b1;
		end
		// Output loads on falling edges only: one word per period, 13 half periods late
		if (fall && fifo_rd_valid) begin // [R1] [R11]
			st_nxt.data = fifo_rd_data; // [R10]
			if (i_top_bit_flip_select == paop_pkg::twos_complement_coding) begin
				st_nxt.data[paop_pkg::DATA_LINE_TOP] = ~fifo_rd_data[paop_pkg::DATA_LINE_TOP]; // [R6]
			end // [R5]
			st_nxt.data_vld = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.data <= paop_pkg::DATA_RST;
			st_r.oe_n <= paop_pkg::OE_N_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	paop_fifo #(
		.WIDTH(paop_pkg::DATA_W),
		.DEPTH(paop_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_wr_valid(st_r.corr_vld),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(st_r.corr),
		.o_rd_valid(fifo_rd_valid),
		.i_rd_ready(fall),
		.o_rd_data(fifo_rd_data)
	);

	assign o_data = st_r.data;
	assign o_data_oe_n = st_r.oe_n;
	assign o_data_valid = st_r.data_vld;
	assign o_overrun = st_r.overrun;
endmodule

/* logic/paop_pkg.sv */
// Notes on behaviour
// R1 - Sample appears 6.5 convert clocks after start
// R2 - Eleven stages, two bits each, two per period
// R3 - Stages advance on both convert clock edges
// R4 - Per-stage delay lines, then redundant-digit correction
// R5 - Select low gives straight offset binary output
// R6 - Select high inverts only the top bit
// R7 - Output disable high puts data lines hi-z
// R8 - Hi-z control for test only, held static
// R9 - Convert clock should have half duty cycle
// R10 - Top data line carries MSB, bottom LSB
// R11 - Output word updates once per convert period
package paop_pkg;
	localparam int unsigned DATA_W = 12;
	localparam int unsigned STAGES = 11;
	localparam int unsigned STAGE_BITS = 2;
	// Half convert periods from start edge to output edge
	localparam int unsigned LATENCY_HALF = 13;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DATA_LINE_TOP = 11;
	localparam int unsigned DATA_LINE_BOTTOM = 0;
	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
	localparam logic OE_N_RST = 1'h1;
	localparam logic [STAGE_BITS-1:0] DIGIT_MAX = 2'h2;

	typedef enum logic {
		offset_binary_coding = 1'h0,
		twos_complement_coding = 1'h1
	} paop_coding_t;

	typedef struct packed {
		logic vld;
		logic [DATA_W-1:0] res;
		logic [STAGES-1:0][STAGE_BITS-1:0] dig;
	} paop_stage_t;
endpackage

/* verif/paop_capture.sv */
`timescale 1ns/1ps
module paop_capture (
	input wire logic i_clk,
	input wire logic i_halt,
	input wire logic [paop_pkg::DATA_W-1:0] i_data,
	input wire logic i_oe_n,
	output logic o_conv_clk,
	output logic [paop_pkg::DATA_W-1:0] o_cap
);
	logic [1:0] cnt_r = 2'h0;
	initial o_conv_clk = 1'h0;
	// Convert clock freezes while the hi-z control is worked, so no conversion runs
	always @(negedge i_clk) begin
		if (!i_halt) begin
			cnt_r <= cnt_r + 2'h1;
			if (cnt_r == 2'h3)
				o_conv_clk <= !o_conv_clk;
		end
	end
	always @(posedge o_conv_clk)
		o_cap <= i_oe_n ? ~o_cap : i_data;
endmodule

/* verif/paop_checker.sv */
`timescale 1ns/1ps
module paop_checker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_conv_clk,
	input wire logic i_out_disable,
	input wire logic [paop_pkg::DATA_W-1:0] o_data,
	input wire logic o_data_oe_n,
	input wire logic o_data_valid,
	input wire logic o_overrun
);
	logic [5:0] cnt_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			cnt_r <= 6'h00;
		else if (cnt_r != 6'h3F)
			cnt_r <= cnt_r + 6'h01;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence hold6;
		$stable(o_data)[*6];
	endsequence
	a_oe_follow: assert property (1 |=> o_data_oe_n == $past(i_out_disable))
		else $error("oe");
	a_data_once: assert property ($changed(o_data) |=> hold6)
		else $error("twice");
	a_data_phase: assert property ($changed(o_data) |-> !i_conv_clk)
		else $error("phase");
	a_valid_keep: assert property (o_data_valid |=> o_data_valid)
		else $error("valid");
	a_valid_late: assert property ($rose(o_data_valid) |-> cnt_r >= 6'h30)
		else $error("early");
	a_valid_phase: assert property ($rose(o_data_valid) |-> !i_conv_clk)
		else $error("vphase");
	a_no_overrun: assert property (!o_overrun)
		else $error("overrun");
	a_data_idle: assert property (!o_data_valid |-> o_data == 12'h000)
		else $error("idle");
endmodule
bind paop_output_path paop_checker i_paop_checker (.i_clk, .i_rst_n, .i_conv_clk,
	.i_out_disable, .o_data, .o_data_oe_n, .o_data_valid, .o_overrun);

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'h0, i_rst_n = 1'h0, sel = 1'h0, dis = 1'h0, halt = 1'h0;
	logic conv, oe_n, vld, ovr;
	logic [11:0] code = 12'h000, o_data, cap;
	int fail_count = 0, n_tests = 0, cyc = 0;
	always #2.5 i_clk = !i_clk;
	paop_output_path i_paop_output_path (.i_clk, .i_rst_n, .i_conv_clk(conv),
		.i_sample_code(code), .i_top_bit_flip_select(sel), .i_out_disable(dis),
		.o_data, .o_data_oe_n(oe_n), .o_data_valid(vld), .o_overrun(ovr));
	paop_capture i_paop_capture (.i_clk, .i_data(o_data), .i_oe_n(oe_n),
		.i_halt(halt), .o_conv_clk(conv), .o_cap(cap));
	task automatic cmp(input logic [11:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_stream(input logic flip);
		logic [11:0] tab [8] = '{12'hFFF, 12'h000, 12'h800, 12'h7FF, 12'h001, 12'hA5C, 12'h3C3, 12'hFFE};
		sel = flip;
		for (int i = 0; i < 16; i++) begin
			@(negedge conv);
			@(negedge i_clk);
			if (i >= 8)
				cmp(cap, tab[i-8] ^ {flip, 11'h000});
			code = tab[i%8];
		end
		$display("stream done");
	endtask
	task automatic t_hiz;
		cmp({10'h000, vld, ovr}, 12'h002);
		// Stop the convert clock first; the model reads the old halt on this edge and sees it from the next negedge
		halt <= 1'h1;
		repeat (4) @(negedge i_clk);
		dis = 1'h1;
		repeat (3) @(negedge i_clk);
		cmp({11'h000, oe_n}, 12'h001);
		dis = 1'h0;
		repeat (3) @(negedge i_clk);
		cmp({11'h000, oe_n}, 12'h000);
		halt <= 1'h0;
		$display("hiz done");
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(negedge i_clk);
		i_rst_n = 1'h1;
		t_stream(1'h0);
		t_stream(1'h1);
		t_hiz();
		close_out();
	end
endmodule
